// >>> alta_params.svh
// constants for the lookup table access engine: offsets, fields, codes
// assumes a 12-bit byte address on the register port, 32-bit data
`ifndef ALTA_PARAMS_SVH
`define ALTA_PARAMS_SVH

// register byte addresses
`define ALTA_INDEX0_ADDR 12'h400
`define ALTA_INDEX1_ADDR 12'h404
`define ALTA_CTRL_ADDR   12'h408
`define ALTA_EVENT_ADDR  12'h40c
`define ALTA_ENTRY1_ADDR 12'h420
`define ALTA_ENTRY2_ADDR 12'h424
`define ALTA_ENTRY3_ADDR 12'h428
`define ALTA_ENTRY4_ADDR 12'h42c

// control register fields
`define ALTA_CTRL_CODE_LSB  0
`define ALTA_CTRL_POS_BIT   2
`define ALTA_CTRL_HASH_LSB  3
`define ALTA_CTRL_VLAN_BIT  5
`define ALTA_CTRL_GO_BIT    7
`define ALTA_CTRL_FOUND_BIT 8
`define ALTA_CTRL_FOD_BIT   9
`define ALTA_CTRL_COUNT_LSB 16

// operation codes
`define ALTA_OP_WRITE  2'h1
`define ALTA_OP_READ   2'h2
`define ALTA_OP_SEARCH 2'h3

// event status bits, write one to clear
`define ALTA_EV_AFULL 0
`define ALTA_EV_WFAIL 1
`define ALTA_EV_LFAIL 2

// freshness counter value loaded when a source lookup learns or refreshes an entry
`define ALTA_AGE_RELOAD 3'h7

// packed table word layout
`define ALTA_T_STATIC   71
`define ALTA_T_SRCF     70
`define ALTA_T_DSTF     69
`define ALTA_T_AGE_MSB  68
`define ALTA_T_AGE_LSB  66
`define ALTA_T_MSTP_MSB 65
`define ALTA_T_MSTP_LSB 63
`define ALTA_T_OVR      62
`define ALTA_T_PORT_MSB 61
`define ALTA_T_PORT_LSB 55
`define ALTA_T_FID_MSB  54
`define ALTA_T_FID_LSB  48
`define ALTA_T_MAC_MSB  47

`endif

// >>> alta_pkg.sv
// types for the lookup table access engine
// assumes alta_params.svh is on the include path
package alta_pkg;
	typedef enum logic [2:0] {
		ALTA_IDLE   = 3'h1,
		ALTA_SEARCH = 3'h2,
		ALTA_HOLD   = 3'h4
	} alta_state_e;

	typedef logic [71:0] alta_entry_t;
endpackage : alta_pkg

// >>> alta_lookup_table.sv
// forwarding lookup table with its indirect host access engine
// assumes one clock, lookups from the forwarding path at most one a cycle
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "alta_params.svh"

module alta_lookup_table #(
	parameter int PORTS = 7
) (
	input  wire logic                clock,
	input  wire logic                reset,
	input  wire logic [11:0]         busAddr,
	input  wire logic [31:0]         busWrData,
	input  wire logic                busWr,
	input  wire logic                busRd,
	output logic      [31:0]         busRdData,
	input  wire logic                lkValid,
	input  wire logic                lkSource,
	input  wire logic [47:0]         lkMac,
	input  wire logic [6:0]          lkFid,
	input  wire logic [2:0]          lkPort,
	input  wire logic                staticHitIn,
	input  wire logic [PORTS-1:0]    staticMaskIn,
	input  wire logic                agingTick,
	output logic                     lkDone,
	output logic                     lkHit,
	output logic                     lkStatic,
	output logic                     lkDrop,
	output logic      [PORTS-1:0]    lkPortMask
);
	import alta_pkg::*;

	alta_entry_t         lookupTable [4096];
	alta_state_e         state;
	logic                goDone, found, posSel, vlanEn;
	logic [1:0]          opCode, hashSel;
	logic [31:0]         index0, index1;
	alta_entry_t         entryData;
	logic [2:0]          events;
	logic [12:0]         validCount, searchPtr, agePtr;
	logic                ageActive;
	logic [9:0]          bucketIdx, hostBucket, lkBucket;
	logic [47:0]         keyMac;
	logic [6:0]          keyFid;
	alta_entry_t         slotEntry [4];
	logic [3:0]          slotValid, slotStatic, slotMatch;
	logic                matchHit, freeHit, dynHit, victimHit;
	logic [1:0]          matchSlot, freeSlot, lruSlot, victimSlot;
	logic [2:0]          lruAge, staticCnt;
	logic                wrEn, hostGo, searchStep, ageStep;
	logic [11:0]         wrAddr;
	alta_entry_t         wrData, oldEntry, searchEntry, posEntry;
	logic                evAfull, evWfail, evLfail;
	logic [PORTS-1:0]    learnMask;
	logic                readFound;

	function automatic logic entValid(input alta_entry_t e);
		// zero freshness counter on a dynamic entry means empty
		return e[`ALTA_T_STATIC] |
			(e[`ALTA_T_AGE_MSB:`ALTA_T_AGE_LSB] != 3'h0);
	endfunction : entValid

	function automatic logic [9:0] altaHash(input logic [47:0] mac,
		input logic [6:0] filter_group_id, input logic useFid, input logic [1:0] sel);
		logic [49:0] m;
		logic [9:0]  h;
		m = {2'h0, mac};
		unique case (sel)
			2'h0: h = m[9:0] ^ m[19:10] ^ m[29:20] ^ m[39:30] ^ m[49:40];
			2'h1: h = m[9:0] ^ {m[10], m[19:11]} ^ m[29:20] ^
				{m[38:30], m[39]} ^ m[49:40];
			2'h2: h = mac[9:0];
			2'h3: h = mac[47:38];
		endcase
		if (useFid) begin
			h = h ^ {3'h0, filter_group_id};
		end
		return h;
	endfunction : altaHash

	// key and bucket: the forwarding path wins the shared read port
	assign hostBucket = altaHash({index1[15:0], index0}, index1[22:16],
		vlanEn, hashSel);
	assign lkBucket   = altaHash(lkMac, lkFid, vlanEn, hashSel);
	assign bucketIdx  = lkValid ? lkBucket : hostBucket;
	assign keyMac     = lkValid ? lkMac : {index1[15:0], index0};
	assign keyFid     = lkValid ? lkFid : index1[22:16];
	assign learnMask  = PORTS'(1) << lkPort;

	// all four slots of the bucket are read side by side
	genvar g;
	for (g = 0; g < 4; g++) begin : gSlot
		assign slotEntry[g]  = lookupTable[{bucketIdx, 2'(g)}];
		assign slotValid[g]  = entValid(slotEntry[g]);
		assign slotStatic[g] = slotEntry[g][`ALTA_T_STATIC];
		assign slotMatch[g]  = slotValid[g] &&
			slotEntry[g][`ALTA_T_MAC_MSB:0] == keyMac &&
			(!vlanEn ||
			slotEntry[g][`ALTA_T_FID_MSB:`ALTA_T_FID_LSB] == keyFid);
	end

	// slot choice: match, else lowest free, else stalest dynamic
	always_comb begin
		matchHit  = 1'b0;
		matchSlot = 2'h0;
		freeHit   = 1'b0;
		freeSlot  = 2'h0;
		dynHit    = 1'b0;
		lruSlot   = 2'h0;
		lruAge    = 3'h0;
		staticCnt = 3'h0;
		for (int i = 0; i < 4; i++) begin
			if (slotStatic[i]) begin
				staticCnt = staticCnt + 3'h1;
			end
			if (slotMatch[i] && !matchHit) begin
				matchHit  = 1'b1;
				matchSlot = 2'(i);
			end
			if (!slotValid[i] && !freeHit) begin
				freeHit  = 1'b1;
				freeSlot = 2'(i);
			end
			// lowest freshness stands for least recently used
			if (slotValid[i] && !slotStatic[i] && (!dynHit ||
				slotEntry[i][`ALTA_T_AGE_MSB:`ALTA_T_AGE_LSB] < lruAge)) begin
				dynHit  = 1'b1;
				lruSlot = 2'(i);
				lruAge  = slotEntry[i][`ALTA_T_AGE_MSB:`ALTA_T_AGE_LSB];
			end
		end
		victimHit  = matchHit | freeHit | dynHit;
		victimSlot = matchHit ? matchSlot : (freeHit ? freeSlot : lruSlot);
	end

	assign hostGo     = state == ALTA_IDLE && goDone && !lkValid;
	assign searchStep = state == ALTA_SEARCH && goDone && !lkValid;
	assign ageStep    = ageActive && !lkValid && !goDone &&
		state == ALTA_IDLE;
	assign searchEntry = lookupTable[searchPtr[11:0]];
	assign posEntry    = lookupTable[index0[11:0]];
	// found flag that a read would report, kept as a net for the checker
	assign readFound   = posSel ? entValid(posEntry) : matchHit;
	assign oldEntry    = lookupTable[wrAddr];

	// single write port: learning, host writes and aging share it
	always_comb begin
		wrEn    = 1'b0;
		wrAddr  = 12'h000;
		wrData  = entryData;
		evAfull = 1'b0;
		evWfail = 1'b0;
		evLfail = 1'b0;
		if (lkValid && lkSource) begin
			if (matchHit && !slotStatic[matchSlot]) begin
				// refresh and migrate to the port it was seen on
				wrEn   = 1'b1;
				wrAddr = {bucketIdx, matchSlot};
				wrData = slotEntry[matchSlot];
				wrData[`ALTA_T_AGE_MSB:`ALTA_T_AGE_LSB] = `ALTA_AGE_RELOAD;
				wrData[`ALTA_T_PORT_MSB:`ALTA_T_PORT_LSB] = learnMask;
			end else if (!matchHit && victimHit) begin
				wrEn   = 1'b1;
				wrAddr = {bucketIdx, victimSlot};
				wrData = '0;
				wrData[`ALTA_T_AGE_MSB:`ALTA_T_AGE_LSB] = `ALTA_AGE_RELOAD;
				wrData[`ALTA_T_PORT_MSB:`ALTA_T_PORT_LSB] = learnMask;
				wrData[`ALTA_T_FID_MSB:`ALTA_T_FID_LSB] = lkFid;
				wrData[`ALTA_T_MAC_MSB:0] = lkMac;
			end else if (!matchHit) begin
				evLfail = 1'b1;
			end
		end else if (hostGo && opCode == `ALTA_OP_WRITE &&
			entryData[`ALTA_T_STATIC]) begin
			if (posSel) begin
				wrEn   = 1'b1;
				wrAddr = index0[11:0];
			end else if (victimHit) begin
				wrEn    = 1'b1;
				wrAddr  = {bucketIdx, victimSlot};
				evAfull = !slotStatic[victimSlot] &&
					(staticCnt == 3'h2 || staticCnt == 3'h3);
			end else begin
				evWfail = 1'b1;
			end
		end else if (ageStep) begin
			// static entries are left alone by the sweep
			wrEn   = entValid(lookupTable[agePtr[11:0]]) &&
				!lookupTable[agePtr[11:0]][`ALTA_T_STATIC];
			wrAddr = agePtr[11:0];
			wrData = lookupTable[agePtr[11:0]];
			wrData[`ALTA_T_AGE_MSB:`ALTA_T_AGE_LSB] =
				wrData[`ALTA_T_AGE_MSB:`ALTA_T_AGE_LSB] - 3'h1;
		end
	end

	// table storage, cleared by reset so every slot starts empty
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 4096; i++) begin
				lookupTable[i] <= '0;
			end
		end else if (wrEn) begin
			lookupTable[wrAddr] <= wrData;
		end
	end

	// valid entry count follows every write through the one port
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			validCount <= 13'h0000;
		end else if (wrEn) begin
			validCount <= validCount + 13'(entValid(wrData)) -
				13'(entValid(oldEntry));
		end
	end

	// aging sweep, one entry per idle cycle after each tick
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ageActive <= 1'b0;
			agePtr    <= 13'h0000;
		end else if (agingTick) begin
			ageActive <= 1'b1;
			agePtr    <= 13'h0000;
		end else if (ageStep) begin
			agePtr    <= agePtr + 13'h0001;
			ageActive <= agePtr != 13'h0fff;
		end
	end

	// sticky event bits: hardware set wins over a write-one clear
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			events <= 3'h0;
		end else begin
			events <= (events & ~((busWr && busAddr == `ALTA_EVENT_ADDR) ?
				busWrData[2:0] : 3'h0)) | {evLfail, evWfail, evAfull};
		end
	end

	// host engine: control, index and entry registers, search walk
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state     <= ALTA_IDLE;
			goDone    <= 1'b0;
			found     <= 1'b0;
			posSel    <= 1'b0;
			vlanEn    <= 1'b0;
			opCode    <= 2'h0;
			hashSel   <= 2'h0;
			index0    <= 32'h00000000;
			index1    <= 32'h00000000;
			entryData <= '0;
			searchPtr <= 13'h0000;
		end else begin
			if (busWr && !goDone) begin
				unique case (busAddr)
					`ALTA_CTRL_ADDR: begin
						opCode  <= busWrData[`ALTA_CTRL_CODE_LSB+:2];
						posSel  <= busWrData[`ALTA_CTRL_POS_BIT];
						hashSel <= busWrData[`ALTA_CTRL_HASH_LSB+:2];
						vlanEn  <= busWrData[`ALTA_CTRL_VLAN_BIT];
						goDone  <= busWrData[`ALTA_CTRL_GO_BIT];
					end
					`ALTA_INDEX0_ADDR: index0 <= busWrData;
					`ALTA_INDEX1_ADDR: index1 <= {9'h000, busWrData[22:0]};
					`ALTA_ENTRY1_ADDR: begin
						entryData[71:63] <= {busWrData[31:26], busWrData[2:0]};
					end
					`ALTA_ENTRY2_ADDR: begin
						entryData[62:55] <= {busWrData[31], busWrData[6:0]};
					end
					`ALTA_ENTRY3_ADDR: entryData[54:32] <= busWrData[22:0];
					`ALTA_ENTRY4_ADDR: entryData[31:0] <= busWrData;
					default: ;
				endcase
			end
			if (hostGo) begin
				unique case (opCode)
					`ALTA_OP_READ: begin
						goDone <= 1'b0;
						found  <= posSel ? entValid(posEntry) : matchHit;
						if (posSel) begin
							entryData <= entValid(posEntry) ? posEntry : '0;
						end else begin
							entryData <= matchHit ? slotEntry[matchSlot] :
								'0;
						end
					end
					`ALTA_OP_SEARCH: begin
						found     <= 1'b0;
						searchPtr <= 13'h0000;
						state     <= ALTA_SEARCH;
					end
					default: begin
						goDone <= 1'b0;
						found  <= 1'b0;
					end
				endcase
			end
			if (evAfull) begin
				index0[11:0] <= wrAddr;
			end
			if (evWfail) begin
				index0[9:0] <= bucketIdx;
			end
			if (evLfail) begin
				index1[9:0] <= bucketIdx;
			end
			if (searchStep) begin
				if (searchPtr[12]) begin
					goDone    <= 1'b0;
					state     <= ALTA_IDLE;
					entryData <= '0;
				end else if (entValid(searchEntry)) begin
					entryData <= searchEntry;
					found     <= 1'b1;
					state     <= ALTA_HOLD;
					searchPtr <= searchPtr + 13'h0001;
				end else begin
					searchPtr <= searchPtr + 13'h0001;
				end
			end
			if (state == ALTA_HOLD && goDone && busRd &&
				busAddr == `ALTA_ENTRY4_ADDR) begin
				found <= 1'b0;
				state <= ALTA_SEARCH;
			end
			// abort comes last so that its idle state and cleared go win over a search step in its cycle
			if (busWr && goDone && busAddr == `ALTA_CTRL_ADDR &&
				!busWrData[`ALTA_CTRL_GO_BIT]) begin
				goDone <= 1'b0;
				state  <= ALTA_IDLE;
			end
		end
	end

	// register read data, one cycle after the read strobe
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			busRdData <= 32'h00000000;
		end else if (busRd) begin
			unique case (busAddr)
				`ALTA_INDEX0_ADDR: busRdData <= index0;
				`ALTA_INDEX1_ADDR: busRdData <= index1;
				`ALTA_CTRL_ADDR: busRdData <= {3'h0, validCount,
					6'h00, found | !goDone, found, goDone,
					1'b0, vlanEn, hashSel, posSel, opCode};
				`ALTA_EVENT_ADDR: busRdData <= {29'h0, events};
				`ALTA_ENTRY1_ADDR: busRdData <= {entryData[71:66],
					23'h0, entryData[65:63]};
				`ALTA_ENTRY2_ADDR: busRdData <= {entryData[62], 24'h0,
					entryData[61:55]};
				`ALTA_ENTRY3_ADDR: busRdData <= {9'h000, entryData[54:32]};
				`ALTA_ENTRY4_ADDR: busRdData <= entryData[31:0];
				default: busRdData <= 32'h00000000;
			endcase
		end
	end

	// forwarding answer, registered one cycle after the request
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			lkDone     <= 1'b0;
			lkHit      <= 1'b0;
			lkStatic   <= 1'b0;
			lkDrop     <= 1'b0;
			lkPortMask <= '0;
		end else begin
			lkDone <= lkValid;
			if (lkValid && lkSource) begin
				lkHit      <= matchHit;
				lkStatic   <= matchHit && slotStatic[matchSlot];
				lkDrop     <= matchHit && slotEntry[matchSlot][`ALTA_T_SRCF];
				lkPortMask <= '0;
			end else if (lkValid) begin
				// a static hit anywhere outranks a dynamic one here
				if (matchHit && slotStatic[matchSlot] || !staticHitIn) begin
					lkHit      <= matchHit;
					lkStatic   <= matchHit && slotStatic[matchSlot];
					lkDrop     <= matchHit &&
						slotEntry[matchSlot][`ALTA_T_DSTF];
					lkPortMask <= matchHit ? slotEntry[matchSlot]
						[`ALTA_T_PORT_MSB:`ALTA_T_PORT_LSB] : '0;
				end else begin
					lkHit      <= 1'b1;
					lkStatic   <= 1'b1;
					lkDrop     <= 1'b0;
					lkPortMask <= staticMaskIn;
				end
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	read_done_a: assert property (hostGo && opCode == `ALTA_OP_READ
		|=> !goDone && found == $past(readFound))
		else $error("read did not complete in one cycle");
	search_start_a: assert property (hostGo && !busWr &&
		opCode == `ALTA_OP_SEARCH
		|=> !found && searchPtr == 13'h0000 && state == ALTA_SEARCH)
		else $error("search start did not clear found");
	write_fail_a: assert property (evWfail
		|=> events[`ALTA_EV_WFAIL] && index0[9:0] == $past(bucketIdx))
		else $error("write fail not reported");
	learn_fail_a: assert property (evLfail |-> slotStatic == 4'hf)
		else $error("learning blocked with a usable slot");
	count_bound_a: assert property (validCount <= 13'h1000)
		else $error("valid count out of range");
	empty_zero_a: assert property (hostGo && opCode == `ALTA_OP_READ &&
		!posSel && !matchHit |=> entryData == '0)
		else $error("miss left data in entry registers");
	age_static_a: assert property (ageStep && wrEn |-> !oldEntry[71])
		else $error("aging touched a static entry");
	dyn_write_a: assert property (hostGo && opCode == `ALTA_OP_WRITE &&
		!entryData[`ALTA_T_STATIC] |-> !wrEn ##1 !goDone)
		else $error("dynamic host write accepted");
	busy_hold_a: assert property (goDone && busWr &&
		busAddr == `ALTA_CTRL_ADDR |=> $stable(opCode) && $stable(posSel))
		else $error("control changed while busy");
	static_first_a: assert property (lkValid && !lkSource && staticHitIn
		|=> lkDone && lkStatic && lkHit)
		else $error("static match lost priority");
endmodule : alta_lookup_table

// >>> alta_host_model.sv
// host processor model: a register port master for the table engine
// assumes one rising-edge clock shared with the block under test
`timescale 1ns/100ps

module alta_host_model (
	input  wire logic        clock,
	output logic      [11:0] busAddr,
	output logic      [31:0] busWrData,
	output logic             busWr,
	output logic             busRd,
	input  wire logic [31:0] busRdData
);
	// idle bus from time zero so no strobe is ever unknown
	initial begin
		busAddr = 12'h000;
		busWrData = 32'h0000_0000;
		busWr = 1'b0;
		busRd = 1'b0;
	end

	// one-cycle write strobe; the slave never stalls
	task automatic regWrite(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		busWr <= 1'b1;
		busAddr <= a;
		busWrData <= d;
		@(posedge clock);
		busWr <= 1'b0;
	endtask : regWrite

	// data appears in the cycle after the strobe and holds until the next read, so sample it there
	task automatic regRead(input logic [11:0] a, output logic [31:0] d);
		@(posedge clock);
		busRd <= 1'b1;
		busAddr <= a;
		@(posedge clock);
		busRd <= 1'b0;
		#1;
		d = busRdData;
	endtask : regRead
endmodule : alta_host_model

// >>> tb_top.sv
// self-checking bench for the lookup table access engine
// assumes alta_params.svh on the include path and the host model
`timescale 1ns/100ps
`include "alta_params.svh"

module tb_top;
	logic        clock;
	logic        reset;
	logic [11:0] busAddr;
	logic [31:0] busWrData;
	logic        busWr;
	logic        busRd;
	logic [31:0] busRdData;
	logic        lkValid;
	logic        lkSource;
	logic [47:0] lkMac;
	logic [6:0]  lkFid;
	logic [2:0]  lkPort;
	logic        staticHitIn;
	logic [6:0]  staticMaskIn;
	logic        agingTick;
	logic        lkDone;
	logic        lkHit;
	logic        lkStatic;
	logic        lkDrop;
	logic [6:0]  lkPortMask;
	logic [31:0] rd;
	logic [31:0] save;
	int          failCount;
	int          checkCount;

	alta_lookup_table #(.PORTS(7)) dut_u (.clock(clock), .reset(reset),
		.busAddr(busAddr), .busWrData(busWrData), .busWr(busWr),
		.busRd(busRd), .busRdData(busRdData), .lkValid(lkValid),
		.lkSource(lkSource), .lkMac(lkMac), .lkFid(lkFid), .lkPort(lkPort),
		.staticHitIn(staticHitIn), .staticMaskIn(staticMaskIn),
		.agingTick(agingTick), .lkDone(lkDone), .lkHit(lkHit),
		.lkStatic(lkStatic), .lkDrop(lkDrop), .lkPortMask(lkPortMask));

	alta_host_model host_u (.clock(clock), .busAddr(busAddr),
		.busWrData(busWrData), .busWr(busWr), .busRd(busRd),
		.busRdData(busRdData));

	// free-running 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			failCount++;
			$display("[FAIL] %0t word got %h want %h", $time, got, exp);
		end
	endtask : checkWord

	task automatic checkBit(input logic got, input logic exp);
		checkCount++;
		if (got !== exp) begin
			failCount++;
			$display("[FAIL] %0t bit got %b want %b", $time, got, exp);
		end
	endtask : checkBit

	task automatic closeOut();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : closeOut

	task automatic setKey(input logic [31:0] lo, input logic [31:0] hi);
		host_u.regWrite(`ALTA_INDEX0_ADDR, lo);
		host_u.regWrite(`ALTA_INDEX1_ADDR, hi);
	endtask : setKey

	task automatic loadEntry(input logic [31:0] e1, input logic [31:0] e2,
		input logic [31:0] e3, input logic [31:0] e4);
		host_u.regWrite(`ALTA_ENTRY1_ADDR, e1);
		host_u.regWrite(`ALTA_ENTRY2_ADDR, e2);
		host_u.regWrite(`ALTA_ENTRY3_ADDR, e3);
		host_u.regWrite(`ALTA_ENTRY4_ADDR, e4);
	endtask : loadEntry

	// start an operation and poll go until the engine drops it
	task automatic runOp(input logic [31:0] ctrl);
		int n;
		n = 0;
		host_u.regWrite(`ALTA_CTRL_ADDR, ctrl);
		do begin
			host_u.regRead(`ALTA_CTRL_ADDR, rd);
			n++;
		end while (rd[7] !== 1'b0 && n < 50);
		checkBit(rd[7], 1'b0);
	endtask : runOp

	// a search may walk all 4096 places at two cycles a poll
	task automatic pollFod();
		int n;
		n = 0;
		do begin
			host_u.regRead(`ALTA_CTRL_ADDR, rd);
			n++;
		end while (rd[9] !== 1'b1 && n < 2100);
		checkBit(rd[9], 1'b1);
	endtask : pollFod

	task automatic countIs(input logic [31:0] exp);
		host_u.regRead(`ALTA_CTRL_ADDR, rd);
		checkWord({19'h0, rd[28:16]}, exp);
	endtask : countIs

	task automatic lookup(input logic src, input logic [47:0] mac,
		input logic hit, input logic [6:0] smask);
		@(posedge clock);
		lkValid <= 1'b1;
		lkSource <= src;
		lkMac <= mac;
		staticHitIn <= hit;
		staticMaskIn <= smask;
		@(posedge clock);
		lkValid <= 1'b0;
		#1;
		checkBit(lkDone, 1'b1);
	endtask : lookup

	task automatic testReset();
		host_u.regRead(`ALTA_CTRL_ADDR, rd);
		checkWord(rd, 32'h0000_0200);
		host_u.regRead(`ALTA_EVENT_ADDR, rd);
		checkWord(rd, 32'h0000_0000);
		host_u.regWrite(12'h7f0, 32'hffff_ffff);
		host_u.regRead(12'h7f0, rd);
		checkWord(rd, 32'h0000_0000);
		$display("test reset done");
	endtask : testReset

	// five static keys share bucket 5 under the low-bits hash variant
	task automatic testFill();
		logic [31:0] ev;
		for (int k = 0; k < 5; k++) begin
			setKey(32'h5 | (k << 16), 32'h0000_00aa);
			loadEntry(32'h8000_0000, 32'h10 | k, 32'haa, 32'h5 | (k << 16));
			runOp(32'h0000_0091);
			ev = (k == 4) ? 32'h2 : (k >= 2) ? 32'h1 : 32'h0;
			host_u.regRead(`ALTA_EVENT_ADDR, rd);
			checkWord(rd & 32'h7, ev);
			host_u.regRead(`ALTA_INDEX0_ADDR, rd);
			if (k == 4)
				checkWord({22'h0, rd[9:0]}, 32'h5);
			else if (k >= 2)
				checkWord({20'h0, rd[11:0]}, 32'h14 + k);
			host_u.regWrite(`ALTA_EVENT_ADDR, 32'h7);
		end
		countIs(32'h4);
		$display("test fill done");
	endtask : testFill

	task automatic testLearn();
		lookup(1'b1, 48'h00aa_0009_0005, 1'b0, 7'h00);
		host_u.regRead(`ALTA_EVENT_ADDR, rd);
		checkWord(rd & 32'h7, 32'h4);
		host_u.regRead(`ALTA_INDEX1_ADDR, rd);
		checkWord({22'h0, rd[9:0]}, 32'h5);
		host_u.regWrite(`ALTA_EVENT_ADDR, 32'h7);
		lookup(1'b1, 48'h00bb_0000_0009, 1'b0, 7'h00);
		countIs(32'h5);
		lookup(1'b0, 48'h00bb_0000_0009, 1'b1, 7'h40);
		checkBit(lkHit, 1'b1);
		checkWord({25'h0, lkPortMask}, 32'h40);
		lookup(1'b0, 48'h00bb_0000_0009, 1'b0, 7'h00);
		checkBit(lkStatic, 1'b0);
		checkWord({25'h0, lkPortMask}, 32'h08);
		lookup(1'b0, 48'h00aa_0001_0005, 1'b1, 7'h40);
		checkBit(lkStatic, 1'b1);
		checkBit(lkDrop, 1'b0);
		checkWord({25'h0, lkPortMask}, 32'h11);
		setKey(32'h9, 32'hbb);
		runOp(32'h0000_0092);
		checkBit(rd[8], 1'b1);
		host_u.regRead(`ALTA_ENTRY1_ADDR, rd);
		checkWord({26'h0, rd[31:26]}, 32'h7);
		$display("test learn done");
	endtask : testLearn

	task automatic testPosition();
		setKey(32'h0, 32'h0);
		runOp(32'h0000_0096);
		checkBit(rd[8], 1'b0);
		checkBit(rd[9], 1'b1);
		for (int i = 0; i < 4; i++) begin
			host_u.regRead(`ALTA_ENTRY1_ADDR + 12'(4 * i), rd);
			checkWord(rd, 32'h0);
		end
		setKey(32'h14, 32'h0);
		runOp(32'h0000_0096);
		checkBit(rd[8], 1'b1);
		host_u.regRead(`ALTA_ENTRY1_ADDR, rd);
		checkBit(rd[31], 1'b1);
		// group id 1 moves the hash to bucket 4, which is empty
		setKey(32'h5, 32'h0001_00aa);
		runOp(32'h0000_00b2);
		checkBit(rd[8], 1'b0);
		setKey(32'h5, 32'h0000_00aa);
		runOp(32'h0000_00b2);
		checkBit(rd[8], 1'b1);
		setKey(32'h0, 32'h0);
		loadEntry(32'h0, 32'h7f, 32'h0, 32'h1234);
		runOp(32'h0000_0095);
		countIs(32'h5);
		$display("test position done");
	endtask : testPosition

	// index writes are refused while the search holds an entry, and a go-clear write aborts it
	task automatic testAbort();
		host_u.regRead(`ALTA_INDEX0_ADDR, save);
		host_u.regWrite(`ALTA_CTRL_ADDR, 32'h0000_0093);
		pollFod();
		checkBit(rd[7], 1'b1);
		host_u.regWrite(`ALTA_INDEX0_ADDR, 32'hdead_beef);
		host_u.regWrite(`ALTA_CTRL_ADDR, 32'h0000_0013);
		host_u.regRead(`ALTA_CTRL_ADDR, rd);
		checkBit(rd[7], 1'b0);
		host_u.regRead(`ALTA_INDEX0_ADDR, rd);
		checkWord(rd, save);
		$display("test abort done");
	endtask : testAbort

	task automatic testAging();
		for (int t = 0; t < 8; t++) begin
			@(posedge clock);
			agingTick <= 1'b1;
			@(posedge clock);
			agingTick <= 1'b0;
			repeat (5000) @(posedge clock);
		end
		countIs(32'h4);
		$display("test aging done");
	endtask : testAging

	task automatic testSearch();
		int n;
		n = 0;
		host_u.regWrite(`ALTA_CTRL_ADDR, 32'h0000_0093);
		for (int i = 0; i < 6; i++) begin
			pollFod();
			if (rd[7] === 1'b0)
				break;
			checkBit(rd[8], 1'b1);
			host_u.regRead(`ALTA_ENTRY1_ADDR, rd);
			checkBit(rd[31], 1'b1);
			host_u.regRead(`ALTA_ENTRY2_ADDR, rd);
			host_u.regRead(`ALTA_ENTRY3_ADDR, rd);
			host_u.regRead(`ALTA_ENTRY4_ADDR, rd);
			n++;
		end
		checkWord(32'(n), 32'h4);
		host_u.regRead(`ALTA_ENTRY4_ADDR, rd);
		checkWord(rd, 32'h0);
		countIs(32'h4);
		$display("test search done");
	endtask : testSearch

	// main sequence: quiet inputs, reset for 8 cycles, then the tests
	initial begin
		failCount = 0;
		checkCount = 0;
		reset = 1'b1;
		lkValid = 1'b0;
		lkSource = 1'b0;
		lkMac = 48'h0;
		lkFid = 7'h00;
		lkPort = 3'h3;
		staticHitIn = 1'b0;
		staticMaskIn = 7'h00;
		agingTick = 1'b0;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		testReset();
		testFill();
		testLearn();
		testPosition();
		testAbort();
		testAging();
		testSearch();
		closeOut();
	end

	// the tests need about 50000 cycles; a hang is cut off well after
	initial begin
		#(90000 * 40);
		failCount++;
		$display("[FAIL] %0t watchdog expired", $time);
		closeOut();
	end
endmodule : tb_top
